// ### plsc_top.v
// lock detection and search/free-run sequencing for the oscillator loop
`timescale 1ns/1ps
`include "plsc_defines.vh"
// Summary of operation
// - coincidence low only when both inputs high
// - lock when averaged level crosses midpoint
// - averaging rejects isolated beat pulses
// - on lock loss sweep with loop closed
// - sixteen count counter: eight search, eight free
// - free-run opens loop, applies fixed bias
// - repeated free-run command holds loop open
// - without command keep alternating until lock
// - falling free-run input forces search, or lock if locked, immediately
// - auto warning when either switch not auto
// - free-run indicator from phase, switch, command
// - lock warning when lock deasserted
// - rcv/xmt switch overrides external timing
// - free/search switch overrides free-run command at loop, bias and sweep
// - switch free to search restarts cycling
// - on lock stop sweep charging, let decay
// - sweep square wave clocks the counter
module plsc_top #(
	parameter HOLD_CYC = `PLSC_HOLD_CYC
) (
	input wire core_clk_i, // 20 MHz clock
	input wire reset_i, // sync reset, high
	input wire if_lim_i, // limited if signal
	input wire ref_lim_i, // limited reference signal
	input wire sweep_sq_i, // sweep oscillator square wave
	input wire cmd_free_i, // free-run command from command_source_module
	input wire cmd_strobe_i, // pulse: command issued
	input wire [1:0] loop_sw_i, // free/auto/search: 0 auto 1 search 2 free
	input wire [1:0] tr_sw_i, // rcv/auto/xmt: 0 auto 1 rcv 2 xmt
	input wire tr_time_i, // tr_timing_source: high transmit
	output reg coinc_n_o, // coincidence, low when both high
	output reg lock_o, // lock indication
	output reg sweep_chg_o, // sweep charging path closed
	output reg loop_closed_o, // loop switch closed
	output reg bias_en_o, // fixed bias applied
	output reg [7:0] bias_o, // fixed varactor bias code
	output reg transmit_o, // transmit when high
	output reg auto_warn_o, // auto warning led
	output reg free_led_o, // free-run led
	output reg lock_warn_o // lock warning led
);
	localparam ST_LOCK = 3'b001;
	localparam ST_SRCH = 3'b010;
	localparam ST_FREE = 3'b100;
	reg [`PLSC_AVG_W-1:0] avg_r;
	reg lock_r;
	reg [`PLSC_CNT_W-1:0] cnt_r;
	reg [2:0] st_r;
	reg [2:0] st_nxt;
	reg [31:0] hold_r;
	reg cmd_hold_r;
	reg free_sw_q_r;
	wire coinc_n;
	wire sq_q;
	wire cmd_q;
	wire cmd_fall;
	wire stb_q;
	wire [3:0] sw_q;
	wire [3:0] sw_all;
	wire ext_free;
	wire force_free;
	wire force_srch;
	wire sq_rise;
	reg sq_d_r;
	// every asynchronous input except the limited inputs and tr_time_i through its own synchroniser
	// the synchronisers add two cycles of latency to every switch, sweep and command decision;
	// at a sweep period of seconds that delay is invisible, and it
	// keeps metastable levels out of the one-hot state register
	plsc_sync u_sq (.clk_i(core_clk_i), .reset_i(reset_i), .d_i(sweep_sq_i),
		.q_o(sq_q), .fall_o());
	// the command level qualifies the strobe; its falling edge is the
	// search command, and it must act whatever the counter phase
	plsc_sync u_cmd (.clk_i(core_clk_i), .reset_i(reset_i), .d_i(cmd_free_i),
		.q_o(cmd_q), .fall_o(cmd_fall));
	// strobe is used as a level; a strobe shorter than two cycles may
	// be missed, so the command source must hold it for several cycles
	plsc_sync u_stb (.clk_i(core_clk_i), .reset_i(reset_i), .d_i(cmd_strobe_i),
		.q_o(stb_q), .fall_o());
	// both switches packed so one loop can synchronise all four bits
	assign sw_all = {tr_sw_i, loop_sw_i};
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_sw
			wire sw_raw;
			assign sw_raw = sw_all[gi];
			plsc_sync u_sw (.clk_i(core_clk_i), .reset_i(reset_i), .d_i(sw_raw),
				.q_o(sw_q[gi]), .fall_o());
		end
	endgenerate
	// coincidence gate, combinational nand of the raw limited inputs;
	// it feeds only the average and a registered copy, so the raw
	// inputs need no synchroniser: a wrong sample moves the level by one
	assign coinc_n = ~(if_lim_i & ref_lim_i);
	// leaky up/down average: one step per cycle limits slew, so a lone
	// beat-note pulse cannot walk the level across the threshold
	always @(posedge core_clk_i) begin
		if (reset_i) begin
			avg_r <= `PLSC_AVG_RST;
			lock_r <= 1'b0;
		end else begin
			if (!coinc_n && avg_r != `PLSC_AVG_MAX)
				avg_r <= avg_r + 8'h01;
			else if (coinc_n && avg_r != `PLSC_AVG_RST)
				avg_r <= avg_r - 8'h01;
			lock_r <= (avg_r >= `PLSC_LOCK_THR);
		end
	end
	// sweep counter clocked on square-wave rising edges
	assign sq_rise = sq_q & ~sq_d_r;
	// command hold: strobe with free command restarts the hold window
	always @(posedge core_clk_i) begin
		if (reset_i) begin
			hold_r <= 32'h00000000;
			cmd_hold_r <= 1'b0;
			sq_d_r <= 1'b0;
			free_sw_q_r <= 1'b0;
		end else begin
			sq_d_r <= sq_q;
			free_sw_q_r <= force_free;
			if (stb_q && cmd_q) begin
				hold_r <= HOLD_CYC[31:0];
				cmd_hold_r <= 1'b1;
			end else if (cmd_fall || hold_r == 32'h00000001) begin
				hold_r <= 32'h00000000;
				cmd_hold_r <= 1'b0;
			end else if (hold_r != 32'h00000000) begin
				hold_r <= hold_r - 32'h00000001;
			end
		end
	end
	// switches win over the command input
	assign force_free = (sw_q[1:0] == `PLSC_SW_HIGH);
	assign force_srch = (sw_q[1:0] == `PLSC_SW_LOW);
	assign ext_free = force_free | (~force_srch & cmd_hold_r);
	// next state of the search/free-run sequencer
	// search and free-run each last eight sweep rises, taken from the
	// low three counter bits; the top bit only marks which half runs
	// limitation: free-run ignores lock, the loop is open there anyway
	always @* begin
		st_nxt = st_r;
		case (st_r)
			ST_LOCK: begin
				if (!lock_r)
					st_nxt = ST_SRCH;
			end
			ST_SRCH: begin
				if (lock_r)
					st_nxt = ST_LOCK;
				else if (sq_rise && cnt_r[`PLSC_HALF_BIT-1:0] == 3'h7)
					st_nxt = ST_FREE;
			end
			ST_FREE: begin
				if (sq_rise && cnt_r[`PLSC_HALF_BIT-1:0] == 3'h7)
					st_nxt = ST_SRCH;
			end
			default: st_nxt = ST_SRCH;
		endcase
		// falling free-run input, or switch leaving free, forces search, or lock if locked
		if (cmd_fall || (free_sw_q_r && !force_free))
			st_nxt = lock_r ? ST_LOCK : ST_SRCH;
	end
	// state and counter registers
	always @(posedge core_clk_i) begin
		if (reset_i) begin
			st_r <= ST_SRCH;
			cnt_r <= `PLSC_CNT_RST;
		end else begin
			st_r <= st_nxt;
			if (lock_r || cmd_fall || (free_sw_q_r && !force_free))
				cnt_r <= `PLSC_CNT_RST;
			else if (sq_rise)
				cnt_r <= cnt_r + 4'h1;
		end
	end
	// registered outputs; external free-run overrides the sequencer
	// every output comes from a flop so the leds and analog switches
	// never see glitches from the next-state decode
	always @(posedge core_clk_i) begin
		if (reset_i) begin
			coinc_n_o <= 1'b1;
			lock_o <= 1'b0;
			sweep_chg_o <= 1'b0;
			loop_closed_o <= 1'b1;
			bias_en_o <= 1'b0;
			bias_o <= `PLSC_FREE_BIAS;
			transmit_o <= 1'b0;
			auto_warn_o <= 1'b0;
			free_led_o <= 1'b0;
			lock_warn_o <= 1'b1;
		end else begin
			coinc_n_o <= coinc_n;
			lock_o <= lock_r;
			// charging path opened on lock so the ramp decays slowly
			sweep_chg_o <= (st_r == ST_SRCH) & ~ext_free;
			loop_closed_o <= ~((st_r == ST_FREE) | ext_free);
			bias_en_o <= (st_r == ST_FREE) | ext_free;
			bias_o <= `PLSC_FREE_BIAS;
			if (sw_q[3:2] == `PLSC_SW_LOW)
				transmit_o <= 1'b0;
			else if (sw_q[3:2] == `PLSC_SW_HIGH)
				transmit_o <= 1'b1;
			else
				transmit_o <= tr_time_i;
			auto_warn_o <= (sw_q[1:0] != `PLSC_SW_AUTO) | (sw_q[3:2] != `PLSC_SW_AUTO);
			free_led_o <= (st_r == ST_FREE) | force_free | cmd_hold_r;
			lock_warn_o <= ~lock_r;
		end
	end
endmodule // plsc_top

// ### plsc_defines.vh
// constants for the pll lock and search controller
`ifndef PLSC_DEFINES_VH
`define PLSC_DEFINES_VH
`define PLSC_CLK_HZ 20000000
`define PLSC_AVG_W 8
`define PLSC_AVG_MAX 8'hFF
`define PLSC_AVG_RST 8'h00
`define PLSC_LOCK_THR 8'h80
`define PLSC_CNT_W 4
`define PLSC_CNT_RST 4'h0
`define PLSC_HALF_BIT 3
`define PLSC_FREE_BIAS 8'h80
`define PLSC_HOLD_S 53
`define PLSC_HOLD_CYC (`PLSC_HOLD_S * `PLSC_CLK_HZ)
`define PLSC_SW_AUTO 2'h0
`define PLSC_SW_LOW 2'h1
`define PLSC_SW_HIGH 2'h2
`endif

// ### plsc_sync.v
// two flop synchroniser plus edge detector for one level
`timescale 1ns/1ps
module plsc_sync (
	input wire clk_i, // clock
	input wire reset_i, // sync reset
	input wire d_i, // async level
	output wire q_o, // synchronised level
	output wire fall_o // one cycle on falling edge
);
	reg s1_r;
	reg s2_r;
	reg s3_r;
	// first flop feeds only the second
	always @(posedge clk_i) begin
		if (reset_i) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
		end else begin
			s1_r <= d_i;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end
	assign q_o = s2_r;
	assign fall_o = s3_r & ~s2_r;
endmodule // plsc_sync

// ### plsc_monitor.sv
// port assertions for the lock and search controller
`timescale 1ns/1ps
module plsc_monitor (
	input wire core_clk_i, // clk
	input wire reset_i, // rst
	input wire if_lim_i, // if
	input wire ref_lim_i, // ref
	input wire [1:0] loop_sw_i, // sw
	input wire [1:0] tr_sw_i, // sw
	input wire coinc_n_o, // out
	input wire lock_o, // out
	input wire sweep_chg_o, // out
	input wire loop_closed_o, // out
	input wire bias_en_o, // out
	input wire [7:0] bias_o, // out
	input wire transmit_o, // out
	input wire auto_warn_o, // led
	input wire free_led_o, // led
	input wire lock_warn_o // led
);
	// six cycles cover two sync flops plus the output registers
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (reset_i);
	a_coinc_nand: assert property (!$past(reset_i) |-> coinc_n_o ==
		!($past(if_lim_i) && $past(ref_lim_i))) else $error("bad coinc");
	a_bias_fixed: assert property (bias_o == 8'h80) else $error("bad bias");
	a_bias_open: assert property (bias_en_o != loop_closed_o) else $error("bad bias en");
	a_sweep_closed: assert property (sweep_chg_o |-> loop_closed_o) else $error("open");
	a_lock_warn: assert property ($changed(lock_o) |-> ##[0:2] lock_warn_o != lock_o)
		else $error("bad lock warn");
	a_auto_warn: assert property ((tr_sw_i != 2'h0) [*6] |=> auto_warn_o)
		else $error("no warn");
	a_free_sw: assert property ((loop_sw_i == 2'h2) [*6] |=> free_led_o && !loop_closed_o)
		else $error("no free");
	a_rcv_force: assert property ((tr_sw_i == 2'h1) [*6] |=> !transmit_o)
		else $error("tx in rcv");
endmodule // plsc_monitor
bind plsc_top plsc_monitor u_mon (.core_clk_i, .reset_i, .if_lim_i, .ref_lim_i, .loop_sw_i,
	.tr_sw_i, .coinc_n_o, .lock_o, .sweep_chg_o, .loop_closed_o, .bias_en_o, .bias_o,
	.transmit_o, .auto_warn_o, .free_led_o, .lock_warn_o);

// ### plsc_cmd_model.sv
// remote command source that repeats free-run commands while holding
`timescale 1ns/1ps
module plsc_cmd_model #(
	parameter PER = 150 // repeat gap, kept below the hold time
) (
	input wire clk_i, // clock
	input wire hold_i, // keep loop in free-run
	output reg free_o = 1'b0, // command level
	output reg stb_o = 1'b0 // command strobe
);
	integer cnt_r = 0;
	// repeats before the hold runs out; strobe held four cycles
	always @(posedge clk_i) begin
		cnt_r <= (!hold_i || cnt_r == PER - 1) ? 0 : cnt_r + 1;
		free_o <= #1 hold_i;
		stb_o <= #1 hold_i && cnt_r < 4;
	end
endmodule // plsc_cmd_model

// ### tb.sv
// self-checking bench for the lock and search controller
`timescale 1ns/1ps
module tb;
	reg core_clk_i = 1'b0, reset_i = 1'b1, if_lim_i = 1'b0, ref_lim_i = 1'b0, tr_time_i = 1'b0;
	reg sweep_sq_i = 1'b0, hold = 1'b0;
	reg [1:0] loop_sw_i = 2'h0, tr_sw_i = 2'h0;
	wire cmd_free_i, cmd_strobe_i, c, lk, sc, lc, be, tx, aw, fl, lw;
	wire [7:0] bs;
	reg [6:0] exp_q [$];
	integer failures = 0, checked = 0, cyc = 0, i;
	event chk_e;
	plsc_top #(.HOLD_CYC(200)) dut (.core_clk_i, .reset_i, .if_lim_i, .ref_lim_i, .sweep_sq_i,
		.cmd_free_i, .cmd_strobe_i, .loop_sw_i, .tr_sw_i, .tr_time_i, .coinc_n_o(c),
		.lock_o(lk), .sweep_chg_o(sc), .loop_closed_o(lc), .bias_en_o(be), .bias_o(bs),
		.transmit_o(tx), .auto_warn_o(aw), .free_led_o(fl), .lock_warn_o(lw));
	plsc_cmd_model u_cmd (.clk_i(core_clk_i), .hold_i(hold), .free_o(cmd_free_i),
		.stb_o(cmd_strobe_i));
	// 20 MHz clock
	initial begin
		forever #25 core_clk_i = ~core_clk_i;
	end
	// hang guard, far above the planned run of about 1460 cycles
	always @(posedge core_clk_i) begin
		cyc = cyc + 1;
		if (cyc == 8000) begin
			failures = failures + 1;
			summarize;
		end
	end
	task w(input integer n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask
	task cmp(input [6:0] seen, input [6:0] want);
		checked = checked + 1;
		if (seen !== want) begin
			failures = failures + 1;
			$display("[FAIL] %0t seen %h want %h", $time, seen, want);
		end
	endtask
	task note(input [6:0] v);
		exp_q.push_back(v);
		->chk_e;
	endtask
	task sweeps(input integer n);
		repeat (n) begin
			sweep_sq_i = 1'b1;
			w(4);
			sweep_sq_i = 1'b0;
			w(4);
		end
	endtask
	task summarize;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// observer: oldest note against {auto warn, lock warn, sweep, free led, closed, lock, tx}
	always @(chk_e) begin
		cmp({aw, lw, sc, fl, lc, lk, tx}, exp_q.pop_front());
	end
	// stimulus; checks wait out the two-flop synchronisers
	initial begin
		i = $urandom(32'h36dd5875);
		w(12);
		reset_i = 1'b0;
		w(6);
		note(7'h34);
		sweeps(7);
		note(7'h34);
		sweeps(1);
		w(2);
		note(7'h28);
		sweeps(8);
		w(2);
		note(7'h34);
		$display("cycling test done");
		// beat note: coincidence only one cycle in four on average
		if_lim_i = 1'b1;
		repeat (300) begin
			ref_lim_i = ($urandom % 4) == 0;
			w(1);
		end
		ref_lim_i = 1'b0;
		note(7'h34);
		sweeps(3);
		ref_lim_i = 1'b1;
		w(100);
		note(7'h34);
		w(50);
		note(7'h06);
		if_lim_i = 1'b0;
		w(60);
		sweeps(7);
		note(7'h34);
		sweeps(1);
		w(2);
		note(7'h28);
		$display("lock test done");
		sweeps(8);
		hold = 1'b1;
		w(500);
		note(7'h28);
		hold = 1'b0;
		sweeps(8);
		hold = 1'b1;
		w(10);
		hold = 1'b0;
		w(8);
		note(7'h34);
		loop_sw_i = 2'h2;
		w(8);
		note(7'h68);
		loop_sw_i = 2'h1;
		w(8);
		note(7'h74);
		hold = 1'b1;
		w(20);
		note(7'h7C);
		hold = 1'b0;
		loop_sw_i = 2'h0;
		for (i = 0; i < 3; i = i + 1) begin
			tr_sw_i = i[1:0];
			tr_time_i = i != 2;
			w(8);
			note({i != 0, 2'b11, 3'b010, i != 1});
		end
		$display("command and switch test done");
		w(2);
		summarize;
	end
endmodule // tb
